/* bench/fcs_array_model.sv */
`timescale 1ns/100ps
`default_nettype none

module fcs_array_model
	import fcs_pkg::*;
(
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         resetn,
	// Array port
	input  wire logic         arr_req,
	input  wire fcs_arr_cmd_t arr_cmd,
	output var  logic         arr_ack,
	output var  logic [15:0]  arr_rdata,
	output var  logic         arr_rd_err,
	output var  logic         arr_rd_uncorr,
	// Test controls
	input  wire logic         slow,
	input  wire logic         inj_err,
	input  wire logic         inj_uncorr
);
	logic [15:0] fl [logic [23:0]];
	logic [15:0] om [32];
	int          cnt;

	function automatic logic [15:0] rdf(logic [23:0] a);
		return fl.exists(a) ? fl[a] : 16'hffff;
	endfunction

	initial foreach (om[i]) om[i] = 16'hffff;

	// Between answers the read lines toggle, so a stale sample is never a match
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			arr_ack <= 1'b0;
			arr_rdata <= 16'h0000;
			arr_rd_err <= 1'b0;
			arr_rd_uncorr <= 1'b0;
			cnt <= 0;
		end else if (arr_ack || !arr_req || cnt < (slow ? 4 : 0)) begin
			arr_ack <= 1'b0;
			arr_rdata <= ~arr_rdata;
			arr_rd_err <= ~arr_rd_err;
			arr_rd_uncorr <= ~arr_rd_uncorr;
			cnt <= (arr_req && !arr_ack) ? cnt + 1 : 0;
		end else begin
			arr_ack <= 1'b1;
			arr_rd_err <= inj_err;
			arr_rd_uncorr <= inj_uncorr;
			cnt <= 0;
			case (arr_cmd.op)
			FCS_OP_READ: arr_rdata <= rdf(arr_cmd.addr);
			FCS_OP_PROG: fl[arr_cmd.addr] = rdf(arr_cmd.addr) & arr_cmd.wdata;
			FCS_OP_ONCE_READ: arr_rdata <= om[arr_cmd.addr[5:1]];
			// Programming only clears bits, so a second write cannot restore data
			FCS_OP_ONCE_PROG: om[arr_cmd.addr[5:1]] &= arr_cmd.wdata;
			FCS_OP_ERASE_ALL: fl.delete();
			default: ;
			endcase
		end
	end
endmodule

`default_nettype wire

/* bench/fcs_sequencer_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module fcs_sequencer_tb_top
	import fcs_pkg::*;
;
	localparam logic [23:0] LAST = 24'h007fff;
	logic         mclk, resetn, cmd_wr, launch, clr_ae, clr_pv, prot_en, eep, cpu_rd;
	logic         slow, inj_err, inj_unc, cc, ae, pv, ve, ue, sec, req, ack, rerr, runc, inv;
	logic [2:0]   cwi;
	logic [3:0]   mode;
	logic [15:0]  wdat, rdat, ardat;
	logic [23:0]  ps, pe;
	fcs_arr_cmd_t acmd;
	int           seed = 49;
	int           failures = 0;
	int           num_checks = 0;
	bit           sec_e;
	bit           wr [8];
	logic [15:0]  dq [4];
	logic [15:0]  so [8][4];
	logic [15:0]  fsh [logic [23:0]];
	logic [7:0]   codes [4] = '{8'h04, 8'h06, 8'h07, 8'h08};
	logic [2:0]   ixs [4] = '{3'h1, 3'h3, 3'h5, 3'h0};

	fcs_sequencer #(.FLASH_BASE(24'h000000), .FLASH_LAST(LAST)) dut (
		.mclk(mclk), .resetn(resetn), .command_word_index(cwi), .cmd_wr(cmd_wr),
		.cmd_wdata(wdat), .cmd_rdata_q(rdat), .launch(launch), .clr_access_err(clr_ae),
		.clr_prot_viol(clr_pv), .command_complete_flag_q(cc), .access_error_flag_q(ae),
		.protection_violation_flag_q(pv), .verify_error_flag_q(ve),
		.uncorrectable_error_flag_q(ue), .security_released_q(sec), .mode_allow(mode),
		.prot_en(prot_en), .prot_start(ps), .prot_end(pe), .eeprom_protected(eep),
		.arr_req_q(req), .arr_cmd_q(acmd), .arr_ack(ack), .arr_rdata(ardat),
		.arr_rd_err(rerr), .arr_rd_uncorr(runc), .cpu_rd(cpu_rd), .cpu_rd_invalid_q(inv));

	fcs_array_model u_arr (
		.mclk(mclk), .resetn(resetn), .arr_req(req), .arr_cmd(acmd), .arr_ack(ack),
		.arr_rdata(ardat), .arr_rd_err(rerr), .arr_rd_uncorr(runc), .slow(slow),
		.inj_err(inj_err), .inj_uncorr(inj_unc));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task automatic tick;
		@(posedge mclk);
		#1;
	endtask

	task automatic chk(input bit ok, input string m);
		num_checks++;
		if (!ok) begin
			failures++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask

	task automatic conclude;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic ld(input logic [2:0] i, input logic [15:0] d);
		cwi = i;
		wdat = d;
		cmd_wr = 1'b1;
		tick;
	endtask

	function automatic bit e_acc(logic [7:0] c, logic [23:0] a, logic [2:0] ix, bit ow);
		case (c)
		8'h04: return !mode[0] || ix != 3'h1 || a[15:0] > 16'h0007;
		8'h06: return !mode[1] || (ix != 3'h3 && ix != 3'h5) || a[1:0] != 2'h0
			|| {1'b0, a} + (ix == 3'h5 ? 25'h7 : 25'h3) > {1'b0, LAST};
		8'h07: return !mode[2] || ix != 3'h5 || a[15:0] > 16'h0007 || (ow && wr[a[2:0]]);
		8'h08: return !mode[3] || ix != 3'h0;
		default: return 1'b1;
		endcase
	endfunction

	function automatic bit e_prot(logic [7:0] c, logic [23:0] a);
		if (c == 8'h06)
			return prot_en && a >= ps && a <= pe;
		return c == 8'h08 && (prot_en || eep);
	endfunction

	task automatic run(input logic [7:0] c, input logic [23:0] a, input logic [2:0] ix);
		bit          ea, ep, le, mm;
		int          k;
		logic [15:0] o;
		logic [2:0]  p;
		ea = e_acc(c, a, ix, 1'b1);
		ep = e_prot(c, a);
		le = ep || e_acc(c, a, ix, 1'b0);
		mm = 1'b0;
		p = a[2:0];
		ld(3'h0, {c, a[23:16]});
		ld(3'h1, a[15:0]);
		for (int i = 0; i < 4; i++)
			ld(3'(i + 2), dq[i]);
		cmd_wr = 1'b0;
		cwi = ix;
		launch = 1'b1;
		tick;
		launch = 1'b0;
		// Registers stay untouched until complete returns
		for (k = 0; k < 3000 && cc !== 1'b1; k++) begin
			if (k == 3 && !ea && (c == 8'h04 || c == 8'h07))
				chk(inv === 1'b1, "flash read not flagged invalid");
			if (le && req === 1'b1)
				chk(1'b0, "array used after launch error");
			cpu_rd = (k == 2);
			tick;
		end
		cpu_rd = 1'b0;
		chk(k < 3000, "command never completed");
		chk(ae === ea, "access error flag");
		chk(pv === ep, "protection flag");
		if (!ea && !ep) begin
			case (c)
			8'h04: begin
				chk(ve === inj_err && ue === inj_unc, "read error flags");
				for (int i = 0; i < 4; i++) begin
					cwi = 3'(i + 2);
					tick;
					if (!inj_err) chk(rdat === so[p][i], "read once word");
				end
			end
			8'h06: begin
				for (int i = 0; i < (ix == 3'h5 ? 4 : 2); i++) begin
					o = fsh.exists(a + 24'(2 * i)) ? fsh[a + 24'(2 * i)] : 16'hffff;
					mm |= (o & dq[i]) != dq[i];
					fsh[a + 24'(2 * i)] = o & dq[i];
				end
				chk(ve === mm, "program verify flag");
			end
			8'h07: begin
				so[p] = dq;
				wr[p] = 1'b1;
				chk(ve === 1'b0, "program once verify flag");
			end
			default: begin
				fsh.delete();
				sec_e |= !inj_err;
				chk(ve === inj_err && sec === sec_e, "erase all result");
			end
			endcase
		end
		clr_ae = 1'b1;
		clr_pv = 1'b1;
		tick;
		clr_ae = 1'b0;
		clr_pv = 1'b0;
	endtask

	initial begin
		int          r;
		logic [23:0] a;
		{resetn, cmd_wr, launch, clr_ae, clr_pv, prot_en, eep, cpu_rd} = '0;
		{slow, inj_err, inj_unc, sec_e} = '0;
		cwi = 3'h0;
		wdat = 16'h0000;
		mode = 4'hf;
		ps = 24'h002000;
		pe = 24'h003fff;
		foreach (so[i, j]) so[i][j] = 16'hffff;
		foreach (dq[i]) dq[i] = 16'($random(seed));
		repeat (2) @(posedge mclk);
		#1;
		resetn = 1'b1;
		chk(cc === 1'b1 && ae === 1'b0 && pv === 1'b0 && ve === 1'b0, "reset flags");
		chk(ue === 1'b0 && sec === 1'b0 && req === 1'b0 && inv === 1'b0, "reset outputs");
		eep = 1'b1;
		run(8'h08, 24'h0, 3'h0);
		eep = 1'b0;
		inj_err = 1'b1;
		run(8'h08, 24'h0, 3'h0);
		inj_unc = 1'b1;
		run(8'h04, 24'h3, 3'h1);
		{inj_err, inj_unc} = 2'b00;
		run(8'h04, 24'h0, 3'h0);
		run(8'h04, 24'h8, 3'h1);
		run(8'h07, 24'h8, 3'h5);
		run(8'h07, 24'h3, 3'h3);
		run(8'h07, 24'h3, 3'h5);
		dq[0] = ~dq[0];
		run(8'h07, 24'h3, 3'h5);
		run(8'h04, 24'h3, 3'h1);
		run(8'h06, 24'h007ff8, 3'h5);
		run(8'h06, 24'h007ffc, 3'h5);
		run(8'h06, 24'h007ffc, 3'h3);
		run(8'h06, 24'h000102, 3'h3);
		run(8'h06, 24'h000100, 3'h4);
		foreach (dq[i]) dq[i] = 16'($random(seed));
		run(8'h06, 24'h007ff8, 3'h5);
		prot_en = 1'b1;
		run(8'h06, 24'h002000, 3'h3);
		run(8'h08, 24'h0, 3'h0);
		prot_en = 1'b0;
		for (int j = 0; j < 4; j++) begin
			mode = ~(4'h1 << j);
			run(codes[j], 24'h0, ixs[j]);
		end
		for (int n = 0; n < 60; n++) begin
			foreach (dq[i]) dq[i] = 16'($random(seed));
			r = $random(seed);
			mode = (r[7:4] == 4'h0) ? 4'hd : 4'hf;
			slow = r[8];
			prot_en = r[9] & r[10];
			eep = r[11] & r[12] & r[13];
			a = r[3] ? 24'(r[18:16]) : {9'h000, r[30:18], r[5] & r[4], 1'b0};
			run(codes[r[1:0]], a, r[6] ? ixs[r[1:0]] : r[22:20]);
		end
		conclude;
	end

	initial begin
		repeat (20000) @(posedge mclk);
		failures++;
		conclude;
	end
endmodule

`default_nettype wire

/* hdl/fcs_defines.svh */
`ifndef FCS_DEFINES_SVH
`define FCS_DEFINES_SVH

// Command codes in the high byte of command word 0
`define FCS_CODE_READ_ONCE   8'h04
`define FCS_CODE_PROG_FLASH  8'h06
`define FCS_CODE_PROG_ONCE   8'h07
`define FCS_CODE_ERASE_ALL   8'h08

// Command word index expected at launch
`define FCS_IDX_READ_ONCE    3'h1
`define FCS_IDX_PF_ONE_LW    3'h3
`define FCS_IDX_PF_TWO_LW    3'h5
`define FCS_IDX_PROG_ONCE    3'h5
`define FCS_IDX_ERASE_ALL    3'h0

// Command word slots
`define FCS_NUM_WORDS        6
`define FCS_SLOT_DATA0       3'h2
`define FCS_PHRASE_MAX       16'h0007

// Array figures
`define FCS_BLANK_WORD       16'hffff
`define FCS_SPAN_ONE_LW      25'h0000003
`define FCS_SPAN_TWO_LW      25'h0000007
`define FCS_LAST_ONE_LW      2'h1
`define FCS_LAST_TWO_LW      2'h3

// Mode permission bit positions
`define FCS_ALLOW_RO         0
`define FCS_ALLOW_PF         1
`define FCS_ALLOW_PO         2
`define FCS_ALLOW_EA         3

// Reset values
`define FCS_RST_WORD         16'h0000
`define FCS_RST_ADDR         24'h000000

`endif

/* hdl/fcs_pkg.sv */
package fcs_pkg;

	typedef enum logic [2:0] {
		FCS_OP_READ,
		FCS_OP_PROG,
		FCS_OP_ONCE_READ,
		FCS_OP_ONCE_PROG,
		FCS_OP_ERASE_ALL,
		FCS_OP_BLANK_ALL
	} fcs_op_t;

	typedef struct packed {
		fcs_op_t     op;
		logic [23:0] addr;
		logic [15:0] wdata;
	} fcs_arr_cmd_t;

	typedef enum logic [2:0] {
		FCS_S_IDLE,
		FCS_S_READ,
		FCS_S_BLANK,
		FCS_S_PROG,
		FCS_S_VERIFY,
		FCS_S_ERASE,
		FCS_S_EVERIFY,
		FCS_S_DONE
	} fcs_state_t;

endpackage

/* hdl/fcs_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
`include "fcs_defines.svh"

module fcs_sequencer
	import fcs_pkg::*;
#(
	parameter logic [23:0] FLASH_BASE = 24'h000000,
	parameter logic [23:0] FLASH_LAST = 24'h007fff
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         resetn,
	// Command word load and readback
	input  wire logic [2:0]   command_word_index,
	input  wire logic         cmd_wr,
	input  wire logic [15:0]  cmd_wdata,
	output var  logic [15:0]  cmd_rdata_q,
	// Launch and flag clears
	input  wire logic         launch,
	input  wire logic         clr_access_err,
	input  wire logic         clr_prot_viol,
	// Status flags
	output var  logic         command_complete_flag_q,
	output var  logic         access_error_flag_q,
	output var  logic         protection_violation_flag_q,
	output var  logic         verify_error_flag_q,
	output var  logic         uncorrectable_error_flag_q,
	output var  logic         security_released_q,
	// Mode and protection
	input  wire logic [3:0]   mode_allow,
	input  wire logic         prot_en,
	input  wire logic [23:0]  prot_start,
	input  wire logic [23:0]  prot_end,
	input  wire logic         eeprom_protected,
	// Array port
	output var  logic         arr_req_q,
	output var  fcs_arr_cmd_t arr_cmd_q,
	input  wire logic         arr_ack,
	input  wire logic [15:0]  arr_rdata,
	input  wire logic         arr_rd_err,
	input  wire logic         arr_rd_uncorr,
	// Processor read watch
	input  wire logic         cpu_rd,
	output var  logic         cpu_rd_invalid_q
);

	logic [15:0] words_q [`FCS_NUM_WORDS];
	fcs_state_t  state_q;
	logic [1:0]  cnt_q;
	logic [1:0]  last_q;
	logic        once_q;
	logic [23:0] base_q;
	logic [7:0]  code;
	logic [23:0] gaddr;
	logic [15:0] pidx;
	logic [24:0] pf_end;
	logic        go;
	logic        chk_acc;
	logic        chk_prot;
	logic        active;
	logic        ack_last;
	logic [2:0]  slot;

	assign code     = words_q[0][15:8];
	assign gaddr    = {words_q[0][7:0], words_q[1]};
	assign pidx     = words_q[1];
	assign slot     = 3'({1'b0, cnt_q}) + `FCS_SLOT_DATA0;
	assign ack_last = arr_ack && (cnt_q == last_q);
	// Pending access and protection errors block a launch; software must clear them first
	assign go = launch && command_complete_flag_q &&
		!access_error_flag_q && !protection_violation_flag_q;
	assign active = (state_q != FCS_S_IDLE) && (state_q != FCS_S_DONE);

	// Launch checks, all taken in the launch cycle
	always_comb begin
		pf_end   = {1'b0, gaddr} + ((command_word_index == `FCS_IDX_PF_TWO_LW) ?
			`FCS_SPAN_TWO_LW : `FCS_SPAN_ONE_LW);
		chk_acc  = 1'b0;
		chk_prot = 1'b0;
		case (code)
			`FCS_CODE_READ_ONCE:
				chk_acc = (command_word_index != `FCS_IDX_READ_ONCE) ||
					!mode_allow[`FCS_ALLOW_RO] ||
					(pidx > `FCS_PHRASE_MAX);
			`FCS_CODE_PROG_FLASH: begin
				chk_acc = ((command_word_index != `FCS_IDX_PF_ONE_LW) &&
					(command_word_index != `FCS_IDX_PF_TWO_LW)) ||
					!mode_allow[`FCS_ALLOW_PF] ||
					(gaddr[1:0] != 2'h0) ||
					(gaddr < FLASH_BASE) ||
					(pf_end > {1'b0, FLASH_LAST});
				chk_prot = prot_en && (gaddr >= prot_start) && (gaddr <= prot_end);
			end
			`FCS_CODE_PROG_ONCE:
				chk_acc = (command_word_index != `FCS_IDX_PROG_ONCE) ||
					!mode_allow[`FCS_ALLOW_PO] ||
					(pidx > `FCS_PHRASE_MAX);
			`FCS_CODE_ERASE_ALL: begin
				chk_acc = (command_word_index != `FCS_IDX_ERASE_ALL) ||
					!mode_allow[`FCS_ALLOW_EA];
				chk_prot = prot_en || eeprom_protected;
			end
			default: chk_acc = 1'b1;
		endcase
	end

	// Sequencer state
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_q <= FCS_S_IDLE;
			cnt_q   <= 2'h0;
			last_q  <= 2'h0;
			once_q  <= 1'b0;
			base_q  <= `FCS_RST_ADDR;
		end else begin
			case (state_q)
				FCS_S_IDLE: begin
					cnt_q <= 2'h0;
					if (go) begin
						once_q <= (code == `FCS_CODE_READ_ONCE) ||
							(code == `FCS_CODE_PROG_ONCE);
						base_q <= (code == `FCS_CODE_PROG_FLASH) ? gaddr :
							{18'h0, pidx[2:0], 3'h0};
						last_q <= ((code == `FCS_CODE_PROG_FLASH) &&
							(command_word_index == `FCS_IDX_PF_ONE_LW)) ?
							`FCS_LAST_ONE_LW : `FCS_LAST_TWO_LW;
						if (chk_acc || chk_prot)
							state_q <= FCS_S_DONE;
						else if (code == `FCS_CODE_READ_ONCE)
							state_q <= FCS_S_READ;
						else if (code == `FCS_CODE_PROG_ONCE)
							state_q <= FCS_S_BLANK;
						else if (code == `FCS_CODE_PROG_FLASH)
							state_q <= FCS_S_PROG;
						else
							state_q <= FCS_S_ERASE;
					end
				end
				FCS_S_READ, FCS_S_VERIFY: begin
					if (arr_ack)
						cnt_q <= cnt_q + 2'h1;
					if (ack_last)
						state_q <= FCS_S_DONE;
				end
				FCS_S_BLANK: begin
					if (arr_ack)
						cnt_q <= cnt_q + 2'h1;
					if (arr_ack && (arr_rdata != `FCS_BLANK_WORD))
						state_q <= FCS_S_DONE;
					else if (ack_last)
						state_q <= FCS_S_PROG;
				end
				FCS_S_PROG: begin
					// Restart the count so the verify pass begins at the first word
					if (arr_ack)
						cnt_q <= ack_last ? 2'h0 : cnt_q + 2'h1;
					if (ack_last)
						state_q <= FCS_S_VERIFY;
				end
				FCS_S_ERASE:
					if (arr_ack)
						state_q <= FCS_S_EVERIFY;
				FCS_S_EVERIFY:
					if (arr_ack)
						state_q <= FCS_S_DONE;
				default: state_q <= FCS_S_IDLE; // Done, and any stray code
			endcase
		end
	end
	// Array requests; one access at a time, request drops for a cycle after each ack
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			arr_req_q <= 1'b0;
			arr_cmd_q <= '0;
		end else if (arr_ack) begin
			arr_req_q <= 1'b0;
		end else if (active && !arr_req_q) begin
			arr_req_q       <= 1'b1;
			arr_cmd_q.addr  <= base_q + {21'h0, cnt_q, 1'b0};
			arr_cmd_q.wdata <= words_q[slot];
			case (state_q)
				FCS_S_PROG:     arr_cmd_q.op <= once_q ? FCS_OP_ONCE_PROG : FCS_OP_PROG;
				FCS_S_ERASE:    arr_cmd_q.op <= FCS_OP_ERASE_ALL;
				FCS_S_EVERIFY:  arr_cmd_q.op <= FCS_OP_BLANK_ALL;
				default:        arr_cmd_q.op <= once_q ? FCS_OP_ONCE_READ : FCS_OP_READ;
			endcase
		end
	end
	// Command words; software loads them only while idle
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < `FCS_NUM_WORDS; i++)
				words_q[i] <= `FCS_RST_WORD;
			cmd_rdata_q <= `FCS_RST_WORD;
		end else begin
			if (state_q == FCS_S_READ && arr_ack)
				words_q[slot] <= arr_rdata;
			else if (cmd_wr && state_q == FCS_S_IDLE &&
				command_word_index < 3'(`FCS_NUM_WORDS))
				words_q[command_word_index] <= cmd_wdata;
			cmd_rdata_q <= (command_word_index < 3'(`FCS_NUM_WORDS)) ?
				words_q[command_word_index] : `FCS_RST_WORD;
		end
	end
	// Complete flag low from accepted launch to the end of the command
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			command_complete_flag_q <= 1'b1;
		else if (go)
			command_complete_flag_q <= 1'b0;
		else if (state_q == FCS_S_DONE)
			command_complete_flag_q <= 1'b1;
	end
	// Launch errors and the blank check error; a new error wins over a clear in the same cycle
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			access_error_flag_q         <= 1'b0;
			protection_violation_flag_q <= 1'b0;
		end else begin
			access_error_flag_q <= (go && chk_acc) ||
				(state_q == FCS_S_BLANK && arr_ack &&
				arr_rdata != `FCS_BLANK_WORD) ||
				(access_error_flag_q && !clr_access_err);
			protection_violation_flag_q <= (go && chk_prot) ||
				(protection_violation_flag_q && !clr_prot_viol);
		end
	end
	// Read and verify results, cleared by each accepted launch
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			verify_error_flag_q        <= 1'b0;
			uncorrectable_error_flag_q <= 1'b0;
		end else if (go) begin
			verify_error_flag_q        <= 1'b0;
			uncorrectable_error_flag_q <= 1'b0;
		end else if (arr_ack) begin
			case (state_q)
				FCS_S_READ, FCS_S_EVERIFY: begin
					verify_error_flag_q        <= verify_error_flag_q | arr_rd_err;
					uncorrectable_error_flag_q <= uncorrectable_error_flag_q | arr_rd_uncorr;
				end
				FCS_S_VERIFY: begin
					verify_error_flag_q <= verify_error_flag_q | arr_rd_err |
						(arr_rdata != arr_cmd_q.wdata);
					uncorrectable_error_flag_q <= uncorrectable_error_flag_q | arr_rd_uncorr;
				end
				default: verify_error_flag_q <= verify_error_flag_q;
			endcase
		end
	end
	// Security stays until a clean erase all; a failed verify keeps it
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			security_released_q <= 1'b0;
		else if (state_q == FCS_S_EVERIFY && arr_ack && !arr_rd_err && !arr_rd_uncorr)
			security_released_q <= 1'b1;
	end
	// Flash reads while the one-time area is busy carry invalid data
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			cpu_rd_invalid_q <= 1'b0;
		else
			cpu_rd_invalid_q <= cpu_rd && once_q && active;
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	sequence s_reject;
		!command_complete_flag_q ##1 command_complete_flag_q;
	endsequence
	property p_ro_index_word;
		go && code == `FCS_CODE_READ_ONCE && command_word_index != `FCS_IDX_READ_ONCE
			|=> access_error_flag_q;
	endproperty
	a_ro_index_word: assert property (p_ro_index_word) else $error("read once index");
	property p_phrase_range;
		go && (code == `FCS_CODE_READ_ONCE || code == `FCS_CODE_PROG_ONCE) &&
			pidx > `FCS_PHRASE_MAX |=> access_error_flag_q;
	endproperty
	a_phrase_range: assert property (p_phrase_range) else $error("phrase range");
	property p_pf_align;
		go && code == `FCS_CODE_PROG_FLASH && gaddr[1:0] != 2'h0 |=> access_error_flag_q;
	endproperty
	a_pf_align: assert property (p_pf_align) else $error("misaligned program");
	property p_pf_index;
		go && code == `FCS_CODE_PROG_FLASH && command_word_index != `FCS_IDX_PF_ONE_LW &&
			command_word_index != `FCS_IDX_PF_TWO_LW |=> access_error_flag_q;
	endproperty
	a_pf_index: assert property (p_pf_index) else $error("program index");
	property p_po_index;
		go && code == `FCS_CODE_PROG_ONCE && command_word_index != `FCS_IDX_PROG_ONCE
			|=> access_error_flag_q;
	endproperty
	a_po_index: assert property (p_po_index) else $error("program once index");
	property p_ea_prot;
		go && code == `FCS_CODE_ERASE_ALL && (prot_en || eeprom_protected)
			|=> protection_violation_flag_q;
	endproperty
	a_ea_prot: assert property (p_ea_prot) else $error("erase all protection");
	property p_reject;
		go && (chk_acc || chk_prot) |=> s_reject ##0 !arr_req_q;
	endproperty
	a_reject: assert property (p_reject) else $error("rejected launch ran");
	property p_once_read_invalid;
		cpu_rd && once_q && active |=> cpu_rd_invalid_q;
	endproperty
	a_once_read_invalid: assert property (p_once_read_invalid) else $error("read valid");
	property p_ea_secure;
		state_q == FCS_S_EVERIFY && arr_ack && !arr_rd_err && !arr_rd_uncorr
			|=> security_released_q ##1 command_complete_flag_q;
	endproperty
	a_ea_secure: assert property (p_ea_secure) else $error("security not released");
endmodule

`default_nettype wire
